// [include/scs_pkg.sv]
`default_nettype none
package scs_pkg;
	// ==========================================
	// bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// ==========================================
	// register map (word address, bit 0 not decoded)
	localparam logic [15:0] REG_SYSTEM_CONTROL = 16'h7018;
	localparam logic [15:0] REG_SYSTEM_STATUS = 16'h701a;
	localparam logic [15:0] REG_INTERRUPT_VECTOR_LATCH = 16'h701e;
	localparam logic [15:0] REG_RSVD_A = 16'h7010;
	localparam logic [15:0] REG_RSVD_B = 16'h7012;
	localparam logic [15:0] REG_RSVD_C = 16'h7014;
	localparam logic [15:0] REG_RSVD_D = 16'h7016;
	localparam logic [15:0] REG_RSVD_E = 16'h701c;
	// ==========================================
	// system_control fields
	localparam int CTL_SOFT_RESET_HI = 15;
	localparam int CTL_SOFT_RESET_LO = 14;
	localparam int CTL_CLK_SEL_HI = 7;
	localparam int CTL_CLK_SEL_LO = 6;
	localparam logic [1:0] CLK_SEL_POR_VALUE = 2'h3;
	localparam logic [1:0] SOFT_RESET_IDLE = 2'h1;
	// ==========================================
	// system_status fields
	localparam int STS_POWERON = 15;
	localparam int STS_BAD_ADDRESS = 12;
	localparam int STS_SOFTWARE = 10;
	localparam int STS_WATCHDOG = 9;
	localparam int STS_PROTECT_OVERRIDE = 5;
	localparam int STS_ANALOG_FAULT = 3;
	localparam int STS_VECTOR_PENDING = 0;
	// ==========================================
	// reserved bits read this value (indeterminate allowed, zero chosen)
	localparam logic [15:0] RSVD_READ_VALUE = 16'h0000;
	// analog supply fault reads as a fault until the synchronised level lands
	localparam logic ANALOG_FAULT_RESET = 1'b1;
	// clock output pin functions
	typedef enum logic [1:0] {
		SCS_CLK_GPIO = 2'h0,
		SCS_CLK_WATCHDOG = 2'h1,
		SCS_CLK_SYSTEM = 2'h2,
		SCS_CLK_CORE = 2'h3
	} scs_clk_sel_t;
endpackage
`default_nettype wire

// [rtl/scs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_regs (
	// clock and resets
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_poweron_reset_signal,
	// peripheral bus
	input wire logic i_bus_sel,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	input wire logic [15:0] i_bus_addr,
	input wire logic [15:0] i_bus_wdata,
	output logic [15:0] o_bus_rdata,
	// reset cause events
	input wire logic i_bad_address_event,
	input wire logic i_watchdog_reset_event,
	// pins and supplies
	input wire logic i_flash_program_voltage_pin,
	input wire logic i_analog_supply_fault,
	input wire logic i_reset_pin_released,
	// vector load
	input wire logic i_vector_load,
	input wire logic [7:0] i_vector_offset,
	// outputs
	output logic o_global_reset_req,
	output logic [1:0] o_clk_out_sel,
	output logic o_flash_program_enable,
	output logic o_watchdog_disable_allowed
);
	// ==========================================
	// pin synchronisers
	logic pgm_v_s;
	logic supply_fault_s;
	logic rel_s;

	scs_sync2 #(.WIDTH(3)) u_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_flash_program_voltage_pin, i_analog_supply_fault, i_reset_pin_released}),
		.o_sync({pgm_v_s, supply_fault_s, rel_s})
	);

	// ==========================================
	// decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
		hit = (a[15:1] == reg_addr[15:1]);
	endfunction

	logic wr_ctl;
	logic wr_sts;
	logic rd_vec;
	assign wr_ctl = i_bus_sel && i_bus_wr && hit(i_bus_addr, scs_pkg::REG_SYSTEM_CONTROL);
	assign wr_sts = i_bus_sel && i_bus_wr && hit(i_bus_addr, scs_pkg::REG_SYSTEM_STATUS);
	assign rd_vec = i_bus_sel && i_bus_rd && hit(i_bus_addr, scs_pkg::REG_INTERRUPT_VECTOR_LATCH);

	// ==========================================
	// state
	// cause flags and clock select sit outside i_sys_rst so they survive
	// ordinary resets; only power-on reset touches them
	logic sw_trigger;
	logic [1:0] clk_sel_q;
	logic [1:0] clk_sel_d;
	logic [1:0] soft_rst_q;
	logic [1:0] soft_rst_d;
	logic rst_req_q;
	logic rst_req_d;
	logic flag_por_q;
	logic flag_por_d;
	logic [2:0] cause_set;
	logic [2:0] cause_q;
	logic ovr_q;
	logic ovr_d;
	logic rel_prev_q;
	logic rel_prev_d;
	logic fault_q;
	logic fault_d;
	logic vec_pend_q;
	logic vec_pend_d;
	logic [7:0] vec_q;
	logic [7:0] vec_d;
	logic [15:0] ctl_word;
	logic [15:0] sts_word;
	logic [15:0] vec_word;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	// ==========================================
	// software reset trigger
	// both bits come from one word, so a half-written pair cannot trigger
	assign sw_trigger = wr_ctl &&
		(i_bus_wdata[scs_pkg::CTL_SOFT_RESET_HI:scs_pkg::CTL_SOFT_RESET_LO]
		!= scs_pkg::SOFT_RESET_IDLE);

	// ==========================================
	// clock output select, power-on domain
	always_comb begin
		clk_sel_d = clk_sel_q;
		if (wr_ctl) begin
			clk_sel_d = i_bus_wdata[scs_pkg::CTL_CLK_SEL_HI:scs_pkg::CTL_CLK_SEL_LO];
		end
	end

	always_ff @(posedge i_clk or posedge i_poweron_reset_signal) begin
		if (i_poweron_reset_signal) begin
			clk_sel_q <= scs_pkg::CLK_SEL_POR_VALUE;
		end else begin
			clk_sel_q <= clk_sel_d;
		end
	end

	// ==========================================
	// soft reset bits and reset request
	always_comb begin
		soft_rst_d = soft_rst_q;
		if (wr_ctl) begin
			soft_rst_d = i_bus_wdata[scs_pkg::CTL_SOFT_RESET_HI:scs_pkg::CTL_SOFT_RESET_LO];
		end
		// one pulse per triggering write, a cycle after it is taken
		rst_req_d = sw_trigger;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			soft_rst_q <= scs_pkg::SOFT_RESET_IDLE;
			rst_req_q <= 1'b0;
		end else begin
			soft_rst_q <= soft_rst_d;
			rst_req_q <= rst_req_d;
		end
	end

	// ==========================================
	// reset cause flags, power-on domain
	// software can only clear; an event in the clearing cycle still sets
	function automatic int cause_bit(input int idx);
		case (idx)
			0: cause_bit = scs_pkg::STS_BAD_ADDRESS;
			1: cause_bit = scs_pkg::STS_SOFTWARE;
			default: cause_bit = scs_pkg::STS_WATCHDOG;
		endcase
	endfunction

	assign cause_set[0] = i_bad_address_event;
	assign cause_set[1] = sw_trigger;
	assign cause_set[2] = i_watchdog_reset_event;

	always_comb begin
		flag_por_d = flag_por_q && !(wr_sts && i_bus_wdata[scs_pkg::STS_POWERON]);
	end

	always_ff @(posedge i_clk or posedge i_poweron_reset_signal) begin
		if (i_poweron_reset_signal) begin
			flag_por_q <= 1'b1;
		end else begin
			flag_por_q <= flag_por_d;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_cause
		logic flag_q;
		logic flag_d;

		always_comb begin
			flag_d = cause_set[g] ||
				(flag_q && !(wr_sts && i_bus_wdata[cause_bit(g)]));
		end

		always_ff @(posedge i_clk or posedge i_poweron_reset_signal) begin
			if (i_poweron_reset_signal) begin
				flag_q <= 1'b0;
			end else begin
				flag_q <= flag_d;
			end
		end

		assign cause_q[g] = flag_q;
	end

	// ==========================================
	// protect override
	// taken on the rising edge of the synchronised release; that edge wins
	// over a clear in the same cycle
	always_comb begin
		rel_prev_d = rel_s;
		ovr_d = ovr_q;
		if (rel_s && !rel_prev_q) begin
			ovr_d = pgm_v_s;
		end else if (!pgm_v_s || (wr_sts && i_bus_wdata[scs_pkg::STS_PROTECT_OVERRIDE])) begin
			ovr_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ovr_q <= 1'b0;
			rel_prev_q <= 1'b0;
		end else begin
			ovr_q <= ovr_d;
			rel_prev_q <= rel_prev_d;
		end
	end

	// ==========================================
	// analog supply fault
	always_comb begin
		fault_d = supply_fault_s;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			fault_q <= scs_pkg::ANALOG_FAULT_RESET;
		end else begin
			fault_q <= fault_d;
		end
	end

	// ==========================================
	// interrupt vector latch
	always_comb begin
		vec_d = vec_q;
		if (i_vector_load) begin
			vec_d = i_vector_offset;
		end
		// a load in the same cycle as the read keeps the bit set
		vec_pend_d = i_vector_load || (vec_pend_q && !rd_vec);
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			vec_pend_q <= 1'b0;
			vec_q <= 8'h00;
		end else begin
			vec_pend_q <= vec_pend_d;
			vec_q <= vec_d;
		end
	end

	// ==========================================
	// register images and read path
	always_comb begin
		ctl_word = scs_pkg::RSVD_READ_VALUE;
		ctl_word[scs_pkg::CTL_SOFT_RESET_HI:scs_pkg::CTL_SOFT_RESET_LO] = soft_rst_q;
		ctl_word[scs_pkg::CTL_CLK_SEL_HI:scs_pkg::CTL_CLK_SEL_LO] = clk_sel_q;
		sts_word = scs_pkg::RSVD_READ_VALUE;
		sts_word[scs_pkg::STS_POWERON] = flag_por_q;
		for (int k = 0; k < 3; k++) begin
			sts_word[cause_bit(k)] = cause_q[k];
		end
		sts_word[scs_pkg::STS_PROTECT_OVERRIDE] = ovr_q;
		sts_word[scs_pkg::STS_ANALOG_FAULT] = fault_q;
		sts_word[scs_pkg::STS_VECTOR_PENDING] = vec_pend_q;
		vec_word = {8'h00, vec_q};
	end

	// data stands for one cycle after the read, zero otherwise
	always_comb begin
		rdata_d = scs_pkg::RSVD_READ_VALUE;
		if (i_bus_sel && i_bus_rd) begin
			if (hit(i_bus_addr, scs_pkg::REG_SYSTEM_CONTROL)) begin
				rdata_d = ctl_word;
			end else if (hit(i_bus_addr, scs_pkg::REG_SYSTEM_STATUS)) begin
				rdata_d = sts_word;
			end else if (hit(i_bus_addr, scs_pkg::REG_INTERRUPT_VECTOR_LATCH)) begin
				rdata_d = vec_word;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// ==========================================
	// outputs
	assign o_bus_rdata = rdata_q;
	assign o_global_reset_req = rst_req_q;
	assign o_clk_out_sel = clk_sel_q;
	assign o_flash_program_enable = ovr_q;
	assign o_watchdog_disable_allowed = ovr_q;
endmodule
`default_nettype wire

// [rtl/scs_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// asynchronous levels in, synchronised out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;
endmodule
`default_nettype wire

// [testbench/scs_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_cpu_model (
	// bus master side
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	output logic o_sel,
	output logic o_wr,
	output logic o_rd,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
	initial begin
		o_sel = 1'b0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end
	// whole words only, so both soft reset bits always travel together
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge i_clk);
		o_sel <= 1'b1;
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_sel <= 1'b0;
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		// released lines show no stale value
		o_addr <= ~a;
		o_wdata <= ~d;
		#1 q = i_rdata;
	endtask
endmodule
`default_nettype wire

// [testbench/scs_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module scs_regs_monitor (
	// watched ports
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_poweron_reset_signal,
	input wire logic i_bus_sel,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	input wire logic [15:0] i_bus_addr,
	input wire logic [15:0] i_bus_wdata,
	input wire logic [15:0] o_bus_rdata,
	input wire logic o_global_reset_req,
	input wire logic [1:0] o_clk_out_sel,
	input wire logic o_flash_program_enable,
	input wire logic o_watchdog_disable_allowed
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst || i_poweron_reset_signal);
	logic wc, rdx, ctl, rsv;
	// address bit 0 is never part of a match
	assign ctl = i_bus_addr[15:1] == 15'h380c;
	assign rsv = i_bus_addr[15:3] == 13'h0e02 || i_bus_addr[15:1] == 15'h380e;
	assign wc = i_bus_sel && i_bus_wr && ctl;
	assign rdx = i_bus_sel && i_bus_rd;
	property p_req; o_global_reset_req == $past(wc && i_bus_wdata[15:14] != 2'h1); endproperty
	a_req: assert property (p_req) else $error("reset request wrong");
	property p_sel; wc |=> o_clk_out_sel == $past(i_bus_wdata[7:6]); endproperty
	a_sel: assert property (p_sel) else $error("clock select not written");
	property p_hold; disable iff (i_poweron_reset_signal) !wc |=> $stable(o_clk_out_sel); endproperty
	a_hold: assert property (p_hold) else $error("clock select moved");
	property p_por; disable iff (1'b0) i_poweron_reset_signal |-> o_clk_out_sel == 2'h3; endproperty
	a_por: assert property (p_por) else $error("clock select not set");
	property p_rsv; rdx && rsv |=> o_bus_rdata == 16'h0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved slot read");
	property p_ctl; rdx && ctl |=> o_bus_rdata[13:8] == 6'h00 && o_bus_rdata[5:0] == 6'h00
		&& o_bus_rdata[7:6] == o_clk_out_sel; endproperty
	a_ctl: assert property (p_ctl) else $error("control read wrong");
	property p_ivr; rdx && i_bus_addr[15:1] == 15'h380f |=> o_bus_rdata[15:8] == 8'h00; endproperty
	a_ivr: assert property (p_ivr) else $error("vector upper byte set");
	property p_ovr; o_flash_program_enable == o_watchdog_disable_allowed; endproperty
	a_ovr: assert property (p_ovr) else $error("override outputs differ");
	property p_ovr_rd; rdx && i_bus_addr[15:1] == 15'h380d |=>
		o_bus_rdata[5] == $past(o_flash_program_enable); endproperty
	a_ovr_rd: assert property (p_ovr_rd) else $error("override bit disagrees");
endmodule
bind scs_regs scs_regs_monitor u_scs_regs_monitor (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_poweron_reset_signal(i_poweron_reset_signal), .i_bus_sel(i_bus_sel), .i_bus_wr(i_bus_wr),
	.i_bus_rd(i_bus_rd), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
	.o_bus_rdata(o_bus_rdata), .o_global_reset_req(o_global_reset_req),
	.o_clk_out_sel(o_clk_out_sel), .o_flash_program_enable(o_flash_program_enable),
	.o_watchdog_disable_allowed(o_watchdog_disable_allowed));
`default_nettype wire

// [testbench/system_config_status_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module system_config_status_regs_tb_top;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b0;
	logic por = 1'b0;
	logic bad = 1'b0, wdog = 1'b0, fpv = 1'b1, fault = 1'b0, rel = 1'b0, vload = 1'b0;
	logic [7:0] voff = 8'h00;
	logic sel, wr, rd, req, fpe, wda;
	logic [15:0] addr, wdata, rdata, q;
	logic [1:0] csel;
	logic [1:0] pat [3] = '{2'h0, 2'h2, 2'h3};
	int n_errors = 0;
	int checks_done = 0;
	always #50 i_clk = ~i_clk;
	scs_cpu_model u_scs_cpu_model (.i_clk(i_clk), .i_rdata(rdata), .o_sel(sel), .o_wr(wr),
		.o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	scs_regs u_scs_regs (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_poweron_reset_signal(por),
		.i_bus_sel(sel), .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_addr(addr), .i_bus_wdata(wdata),
		.o_bus_rdata(rdata), .i_bad_address_event(bad), .i_watchdog_reset_event(wdog),
		.i_flash_program_voltage_pin(fpv), .i_analog_supply_fault(fault),
		.i_reset_pin_released(rel), .i_vector_load(vload), .i_vector_offset(voff),
		.o_global_reset_req(req), .o_clk_out_sel(csel), .o_flash_program_enable(fpe),
		.o_watchdog_disable_allowed(wda));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		u_scs_cpu_model.xfer(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask
	task automatic wrc(input logic [15:0] a, input logic [15:0] d);
		u_scs_cpu_model.xfer(1'b1, a, d, q);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// =====================
	// watchdog, far beyond the roughly 112 cycles of the sequence
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
	// =====================
	// sequence
	initial begin
		// raised at time zero so the asynchronous resets see a real edge
		i_sys_rst <= 1'b1;
		por <= 1'b1;
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		por <= 1'b0;
		rel <= 1'b1;
		repeat (5) @(posedge i_clk);
		chk(fpe, 16'h0001);
		rdc(16'h701a, 16'h8020);
		rdc(16'h7019, 16'h40c0);
		wrc(16'h701b, 16'hffff);
		rdc(16'h701a, 16'h0000);
		chk(fpe, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wrc(16'h7018, 16'h7f3f | 16'(k << 6));
			rdc(16'h7018, 16'h4000 | 16'(k << 6));
			chk(csel, 16'(k));
		end
		foreach (pat[i]) begin
			wrc(16'h7019, {pat[i], 14'h0080});
			chk(req, 16'h0001);
			@(posedge i_clk);
			#1 chk(req, 16'h0000);
			@(posedge i_clk);
			i_sys_rst <= 1'b1;
			repeat (2) @(posedge i_clk);
			i_sys_rst <= 1'b0;
			repeat (5) @(posedge i_clk);
			rdc(16'h701a, 16'h0420);
			rdc(16'h7018, 16'h4080);
			wrc(16'h701a, 16'h0400);
		end
		@(posedge i_clk);
		bad <= 1'b1;
		wdog <= 1'b1;
		vload <= 1'b1;
		voff <= 8'ha5;
		@(posedge i_clk);
		bad <= 1'b0;
		wdog <= 1'b0;
		vload <= 1'b0;
		voff <= 8'h5a;
		rdc(16'h701a, 16'h1221);
		rdc(16'h701f, 16'h00a5);
		rdc(16'h701a, 16'h1220);
		@(posedge i_clk);
		fault <= 1'b1;
		fpv <= 1'b0;
		repeat (5) @(posedge i_clk);
		rdc(16'h701a, 16'h1208);
		chk(wda, 16'h0000);
		wrc(16'h7012, 16'hffff);
		rdc(16'h7013, 16'h0000);
		rdc(16'h701c, 16'h0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
